// >>> verilog/asc_pkg.sv
/*
 * Constants for the secondary serial port frame-sync generator and the
 * two clock error status registers: offsets, field positions, reset
 * values and cycle counts.
 * Assumes a 200 MHz core clock.
 */
`default_nettype none

package asc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ASC_OFS_FSYNC_GEN_CTRL = 8'h3a;
    localparam logic [7:0] ASC_OFS_RATIO_LOW = 8'h3b;
    localparam logic [7:0] ASC_OFS_ERR_A = 8'h3c;
    localparam logic [7:0] ASC_OFS_ERR_B = 8'h3d;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ASC_RST_FSYNC_GEN_CTRL = 8'h00;
    localparam logic [7:0] ASC_RST_RATIO_LOW = 8'h00;
    localparam logic [7:0] ASC_RST_ERR = 8'h00;
    localparam logic [7:0] ASC_UNMAPPED_DATA = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ASC_BIT_INT_SEL = 7;
    localparam int ASC_BIT_INVERT = 6;
    localparam int ASC_RATIO_HI_MSB = 5;
    localparam int ASC_RATIO_W = 14;
    localparam int ASC_BIT_PROC_CLK = 7;
    localparam int ASC_BIT_RATE_CONV = 4;
    localparam int ASC_BIT_ELEM_MATCH = 3;
    localparam int ASC_BIT_DENSITY_MOD = 2;
    localparam int ASC_BIT_CLK_STOP = 1;
    localparam int ASC_BIT_PRI_RATIO = 7;
    localparam int ASC_BIT_SEC_RATIO = 6;
    localparam int ASC_BIT_CTRL_SYNC = 5;
    localparam int ASC_BIT_PRI_SYNC = 4;
    localparam int ASC_BIT_SEC_SYNC = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int ASC_CLK_PERIOD_NS = 5;
    localparam int ASC_STOP_TIME_NS = 1000000;
    localparam int ASC_STOP_CYC =
        (ASC_STOP_TIME_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
    localparam int ASC_INT_BCLK_HALF = 12;
    localparam logic [ASC_RATIO_W-1:0] ASC_RATIO_MIN = 14'h0002;

endpackage

`default_nettype wire

// >>> verilog/asc_fsync_gen.sv
/*
 * Frame-sync pulse generator: counts bit-clock steps and raises a
 * one-step pulse at the start of each frame of ratio steps.
 * Assumes the ratio is stable in its own clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module asc_fsync_gen #(
    parameter int W = 14
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic step_in,
    input wire logic [W-1:0] ratio_in,
    output logic fsync_out
);

    localparam logic [W-1:0] ONE = W'(1);

    logic [W-1:0] cnt_reg;
    logic fsync_reg;
    wire ratio_off = (ratio_in == '0);
    wire frame_end = (cnt_reg >= ratio_in - ONE);

    // Frame counter, pulse on the first step of each frame
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
            fsync_reg <= 1'b0;
        end else if (step_in) begin
            if (ratio_off) begin
                cnt_reg <= '0;
                fsync_reg <= 1'b0;
            end else if (frame_end) begin
                cnt_reg <= '0;
                fsync_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + ONE;
                fsync_reg <= 1'b0;
            end
        end
    end

    assign fsync_out = fsync_reg;

endmodule

`default_nettype wire

// >>> verilog/asc_clock_ratio_top.sv
/*
 * Secondary serial port frame-sync generation control and the two
 * clock error status registers, reached through a byte register port.
 * Assumes the error conditions arrive as levels on clk_in and the
 * external bit clock runs in its own domain.
 */
// Contract
// R1: Source select: 1 internal, 0 external bit clock
// R2: Invert bit flips bit clock for sync only
// R3: Ratio high six bits from control bits 5-0
// R4: Ratio low byte from second register
// R5: Processing clock flag on sync ratio error
// R6: Rate converter flag unless custom ratio used
// R7: Element matching rate flag
// R8: Density modulator clock flag
// R9: Audio clock stopped one millisecond flag
// R10: Primary port ratio fault flag
// R11: Secondary port ratio fault flag
// R12: Controller clock to sync ratio flag
// R13: Primary sync rate change or halt flag
// R14: Secondary sync rate change or halt flag
// R15: Software writes reserved bits as reset value
// R16: Flags read-only, follow condition, zero after reset
`timescale 1ns/1ps
`default_nettype none

module asc_clock_ratio_top
    import asc_pkg::*;
#(
    parameter int STOP_CYCLES = ASC_STOP_CYC,
    parameter int INT_HALF = ASC_INT_BCLK_HALF
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sec_bclk_in,
    input wire logic sec_ctrl_mode_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic pri_sync_src_err_in,
    input wire logic sec_sync_src_err_in,
    input wire logic rate_conv_err_in,
    input wire logic custom_mn_in,
    input wire logic elem_match_err_in,
    input wire logic density_mod_err_in,
    input wire logic pri_ratio_err_in,
    input wire logic sec_ratio_err_in,
    input wire logic ctrl_sync_err_in,
    input wire logic pri_sync_rate_err_in,
    input wire logic sec_sync_rate_err_in,
    output logic [7:0] reg_rdata_out,
    output logic sec_fsync_out,
    output logic int_bclk_out
);

    localparam int HW = ASC_RATIO_W + 1;
    localparam logic [31:0] STOP_LIM = STOP_CYCLES;
    localparam logic [7:0] HALF_LIM = 8'(INT_HALF - 1);

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] low_reg;
    logic [7:0] err_a_reg;
    logic [7:0] err_b_reg;
    logic [7:0] rdata_reg;
    logic [7:0] err_a_next;
    logic [7:0] err_b_next;
    // Address decode
    wire hit_ctrl = (reg_addr_in == ASC_OFS_FSYNC_GEN_CTRL);
    wire hit_low = (reg_addr_in == ASC_OFS_RATIO_LOW);
    wire hit_err_a = (reg_addr_in == ASC_OFS_ERR_A);
    wire hit_err_b = (reg_addr_in == ASC_OFS_ERR_B);
    wire wr_ctrl = reg_wr_in && hit_ctrl;
    wire wr_low = reg_wr_in && hit_low;
    // Read selection, unmapped reads return zero
    wire [7:0] rd_mux = hit_ctrl ? ctrl_reg :
                        hit_low ? low_reg :
                        hit_err_a ? err_a_reg :
                        hit_err_b ? err_b_reg : ASC_UNMAPPED_DATA;
    // Control fields
    wire int_sel = ctrl_reg[ASC_BIT_INT_SEL];
    wire invert = ctrl_reg[ASC_BIT_INVERT];
    // R3: high ratio bits
    // R4: low ratio byte
    wire [ASC_RATIO_W-1:0] ratio_w =
        {ctrl_reg[ASC_RATIO_HI_MSB:0], low_reg};
    // Writable registers and registered read data
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= ASC_RST_FSYNC_GEN_CTRL;
            low_reg <= ASC_RST_RATIO_LOW;
            rdata_reg <= ASC_UNMAPPED_DATA;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= reg_wdata_in;
            end
            if (wr_low) begin
                low_reg <= reg_wdata_in;
            end
            if (reg_rd_in) begin
                rdata_reg <= rd_mux;
            end
        end
    end
    assign reg_rdata_out = rdata_reg;

    // ------------------------------------------------------------
    // Internal bit clock
    // ------------------------------------------------------------
    logic [7:0] div_reg;
    logic int_bclk_reg;
    wire div_wrap = (div_reg == HALF_LIM);
    wire int_rise = div_wrap && !int_bclk_reg;
    wire int_fall = div_wrap && int_bclk_reg;
    // R2: count falling edges when inverted
    wire int_step = invert ? int_fall : int_rise;
    logic int_fsync;

    // Divider toggles the internal bit clock every half period
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_reg <= 8'h00;
            int_bclk_reg <= 1'b0;
        end else if (div_wrap) begin
            div_reg <= 8'h00;
            int_bclk_reg <= !int_bclk_reg;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign int_bclk_out = int_bclk_reg;

    asc_fsync_gen #(
        .W(ASC_RATIO_W)
    ) u_int_gen (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .step_in(int_step),
        .ratio_in(ratio_w),
        .fsync_out(int_fsync)
    );

    // ------------------------------------------------------------
    // Settings handshake towards the link
    // ------------------------------------------------------------
    logic [HW-1:0] hold_reg;
    logic req_reg;
    logic [2:0] ack_sync_reg;
    logic ack_reg;
    wire [HW-1:0] set_w = {invert, ratio_w};
    wire idle = (req_reg == ack_reg);
    wire ack_agree = (ack_sync_reg[1] == ack_sync_reg[2]);
    // Launch a new setting only when the previous one was taken
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hold_reg <= '0;
            req_reg <= 1'b0;
        end else if (idle && (set_w != hold_reg)) begin
            hold_reg <= set_w;
            req_reg <= !req_reg;
        end
    end
    // Acknowledge toggle back from the link
    logic lnk_seen_reg;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_sync_reg <= 3'h0;
            ack_reg <= 1'b0;
        end else begin
            ack_sync_reg <= {ack_sync_reg[1:0], lnk_seen_reg};
            if (ack_agree) begin
                ack_reg <= ack_sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Link domain on the external bit clock
    // ------------------------------------------------------------
    logic [2:0] lnk_req_reg;
    logic [HW-1:0] lnk_set_reg;
    logic lnk_fsync_reg;
    logic lnk_tgl_reg;
    logic pos_fsync;
    logic neg_fsync;
    wire sec_bclk_n = !sec_bclk_in;
    wire lnk_agree = (lnk_req_reg[1] == lnk_req_reg[2]);
    wire lnk_new = lnk_agree && (lnk_req_reg[2] != lnk_seen_reg);
    wire lnk_invert = lnk_set_reg[HW-1];
    wire [ASC_RATIO_W-1:0] lnk_ratio = lnk_set_reg[ASC_RATIO_W-1:0];
    // Take the held setting once the request toggle settles
    always_ff @(posedge sec_bclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lnk_req_reg <= 3'h0;
            lnk_seen_reg <= 1'b0;
            lnk_set_reg <= '0;
        end else begin
            lnk_req_reg <= {lnk_req_reg[1:0], req_reg};
            if (lnk_new) begin
                lnk_seen_reg <= lnk_req_reg[2];
                lnk_set_reg <= hold_reg;
            end
        end
    end

    asc_fsync_gen #(
        .W(ASC_RATIO_W)
    ) u_pos_gen (
        .clk_in(sec_bclk_in),
        .rst_n_in(rst_n_in),
        .step_in(1'b1),
        .ratio_in(lnk_ratio),
        .fsync_out(pos_fsync)
    );

    asc_fsync_gen #(
        .W(ASC_RATIO_W)
    ) u_neg_gen (
        .clk_in(sec_bclk_n),
        .rst_n_in(rst_n_in),
        .step_in(1'b1),
        .ratio_in(lnk_ratio),
        .fsync_out(neg_fsync)
    );

    // R2: pick the falling-edge generator when inverted
    always_ff @(posedge sec_bclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lnk_fsync_reg <= 1'b0;
            lnk_tgl_reg <= 1'b0;
        end else begin
            lnk_fsync_reg <= lnk_invert ? neg_fsync : pos_fsync;
            lnk_tgl_reg <= !lnk_tgl_reg;
        end
    end

    // ------------------------------------------------------------
    // Link signals back into the core clock
    // ------------------------------------------------------------
    logic [2:0] fs_sync_reg;
    logic [2:0] act_sync_reg;
    logic ext_fsync_reg;
    logic [31:0] stop_cnt_reg;
    logic fsync_reg;
    wire fs_agree = (fs_sync_reg[1] == fs_sync_reg[2]);
    wire act_seen = (act_sync_reg[1] != act_sync_reg[2]);
    wire clk_stopped = (stop_cnt_reg >= STOP_LIM);
    // Synchronise the external frame sync and bit-clock activity
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fs_sync_reg <= 3'h0;
            act_sync_reg <= 3'h0;
            ext_fsync_reg <= 1'b0;
        end else begin
            fs_sync_reg <= {fs_sync_reg[1:0], lnk_fsync_reg};
            act_sync_reg <= {act_sync_reg[1:0], lnk_tgl_reg};
            if (fs_agree) begin
                ext_fsync_reg <= fs_sync_reg[2];
            end
        end
    end

    // R9: count core cycles with no bit-clock activity
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stop_cnt_reg <= 32'h0;
        end else if (act_seen) begin
            stop_cnt_reg <= 32'h0;
        end else if (!clk_stopped) begin
            stop_cnt_reg <= stop_cnt_reg + 32'h1;
        end
    end

    // R1: choose internal or external generated sync
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fsync_reg <= 1'b0;
        end else if (!sec_ctrl_mode_in) begin
            fsync_reg <= 1'b0;
        end else begin
            fsync_reg <= int_sel ? int_fsync : ext_fsync_reg;
        end
    end
    assign sec_fsync_out = fsync_reg;

    // ------------------------------------------------------------
    // Error status
    // ------------------------------------------------------------
    // R11: in controller mode, a ratio below the minimum is also a fault
    wire sec_ratio_short = sec_ctrl_mode_in && (ratio_w < ASC_RATIO_MIN);

    // Build first error status byte, reserved bits zero
    always_comb begin
        err_a_next = ASC_RST_ERR;
        // R5: ratio to source error
        err_a_next[ASC_BIT_PROC_CLK] =
            pri_sync_src_err_in || sec_sync_src_err_in;
        // R6: masked for custom ratio
        err_a_next[ASC_BIT_RATE_CONV] = rate_conv_err_in && !custom_mn_in;
        // R7: element matching rate
        err_a_next[ASC_BIT_ELEM_MATCH] = elem_match_err_in;
        // R8: density modulator clock
        err_a_next[ASC_BIT_DENSITY_MOD] = density_mod_err_in;
        // R9: stopped audio clock
        err_a_next[ASC_BIT_CLK_STOP] = clk_stopped;
    end

    // Build second error status byte, reserved bits zero
    always_comb begin
        err_b_next = ASC_RST_ERR;
        // R10: primary ratio fault
        err_b_next[ASC_BIT_PRI_RATIO] = pri_ratio_err_in;
        // R11: secondary ratio fault
        err_b_next[ASC_BIT_SEC_RATIO] = sec_ratio_err_in || sec_ratio_short;
        // R12: controller clock ratio
        err_b_next[ASC_BIT_CTRL_SYNC] = ctrl_sync_err_in;
        // R13: primary sync rate
        err_b_next[ASC_BIT_PRI_SYNC] = pri_sync_rate_err_in;
        // R14: secondary sync rate
        err_b_next[ASC_BIT_SEC_SYNC] = sec_sync_rate_err_in;
    end

    // R16: flags follow conditions, writes ignored
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_a_reg <= ASC_RST_ERR;
            err_b_reg <= ASC_RST_ERR;
        end else begin
            err_a_reg <= err_a_next;
            err_b_reg <= err_b_next;
        end
    end

endmodule

`default_nettype wire

// >>> tb/asc_bclk_model.sv
/*
 * Far-side bit clock source for the secondary serial port.
 * Assumes run_in is driven by the bench; the clock parks low when stopped.
 */
`timescale 1ns/1ps
`default_nettype none

module asc_bclk_model #(
    parameter realtime HALF_NS = 62.5
) (
    input wire logic run_in,
    output logic bclk_out
);
    // ------------------------------------------------------------
    // Clock generation
    // ------------------------------------------------------------
    // Free phase offset, and a stop only ever lands on the low level
    initial begin
        bclk_out = 1'b0;
        #3.7;
        forever begin
            #HALF_NS;
            if (run_in || bclk_out) begin
                bclk_out = ~bclk_out;
            end
        end
    end
endmodule

`default_nettype wire

// >>> tb/asc_props.sv
/*
 * Checker for the register port, flags and clocks of the top module.
 * Assumes a bind from the bench that hands on INT_HALF.
 */
`timescale 1ns/1ps
`default_nettype none

module asc_props
    import asc_pkg::*;
#(
    parameter int INT_HALF = ASC_INT_BCLK_HALF
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sec_ctrl_mode_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic pri_sync_src_err_in,
    input wire logic sec_sync_src_err_in,
    input wire logic rate_conv_err_in,
    input wire logic custom_mn_in,
    input wire logic elem_match_err_in,
    input wire logic density_mod_err_in,
    input wire logic pri_ratio_err_in,
    input wire logic sec_ratio_err_in,
    input wire logic ctrl_sync_err_in,
    input wire logic pri_sync_rate_err_in,
    input wire logic sec_sync_rate_err_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic sec_fsync_out,
    input wire logic int_bclk_out
);
    // ------------------------------------------------------------
    // Helpers and properties
    // ------------------------------------------------------------
    logic [1:0] up_reg;
    logic [8:0] half_reg;
    logic last_reg;
    logic seen_reg;
    // Decodes of reads and of the expected flag bytes
    wire logic flip = int_bclk_out != last_reg;
    wire logic up_ok = up_reg == 2'h3;
    wire logic rd_a = up_ok && reg_rd_in && reg_addr_in == ASC_OFS_ERR_A;
    wire logic rd_b = up_ok && reg_rd_in && reg_addr_in == ASC_OFS_ERR_B;
    wire logic rd_x = reg_rd_in && (reg_addr_in < ASC_OFS_FSYNC_GEN_CTRL ||
        reg_addr_in > ASC_OFS_ERR_B);
    wire logic [7:0] cond_a = {pri_sync_src_err_in | sec_sync_src_err_in,
        2'h0, rate_conv_err_in & ~custom_mn_in, elem_match_err_in,
        density_mod_err_in, 2'h0};
    wire logic [7:0] cond_b = {pri_ratio_err_in, 1'b0, ctrl_sync_err_in,
        pri_sync_rate_err_in, sec_sync_rate_err_in, 3'h0};
    // Cycles since reset and since the last internal clock edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_reg <= 2'h0;
            half_reg <= 9'h000;
            last_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            up_reg <= up_ok ? up_reg : up_reg + 2'h1;
            half_reg <= flip ? 9'h000 : half_reg + 9'h001;
            last_reg <= int_bclk_out;
            seen_reg <= seen_reg | flip;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_wr_low;
        reg_wr_in && !reg_rd_in && reg_addr_in == ASC_OFS_RATIO_LOW;
    endsequence
    sequence s_rd_low;
        reg_rd_in && !reg_wr_in && reg_addr_in == ASC_OFS_RATIO_LOW;
    endsequence
    chk_low_readback: assert property (
        s_wr_low ##1 s_rd_low |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("ratio low byte read back wrong");
    chk_err_a_bits: assert property (
        rd_a |=> (reg_rdata_out & 8'hfd) == $past(cond_a, 2))
        else $error("error status a does not follow conditions");
    chk_err_b_bits: assert property (
        rd_b |=> (reg_rdata_out & 8'hbf) == $past(cond_b, 2))
        else $error("error status b does not follow conditions");
    chk_sec_ratio_flag: assert property (
        rd_b && $past(sec_ratio_err_in) |=> reg_rdata_out[6])
        else $error("secondary ratio fault not shown");
    chk_unmapped_zero: assert property (
        rd_x |=> reg_rdata_out == ASC_UNMAPPED_DATA)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (
        !reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    chk_mode_off_quiet: assert property (
        !sec_ctrl_mode_in [*6] |-> !sec_fsync_out)
        else $error("frame sync outside controller mode");
    chk_bclk_half: assert property (
        seen_reg && flip |-> half_reg == 9'(INT_HALF - 1))
        else $error("internal bit clock half period wrong");
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
/*
 * Bench for asc_clock_ratio_top: registers, flags, frame sync, clock stop.
 * Assumes asc_bclk_model as the far-side bit clock source.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import asc_pkg::*;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    localparam int HALF = 2;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic run = 1'b1;
    logic sec_ctrl_mode_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [10:0] cond = 11'h000;
    logic [31:0] seed = 32'h43;
    logic [31:0] r;
    wire logic sec_bclk_in;
    wire logic sec_fsync_out;
    wire logic int_bclk_out;
    wire logic [7:0] reg_rdata_out;
    wire logic c0, c1, c2, c3, c4, c5, c6, c7, c8, c9, c10;
    logic [7:0] exp_q[$];
    int error_cnt = 0;
    int n_tests = 0;
    int cyc_cnt = 0;
    int g;
    int k;
    assign {c10, c9, c8, c7, c6, c5, c4, c3, c2, c1, c0} = cond;
    always #2.5 clk_in = ~clk_in;
    asc_bclk_model u_bclk (.run_in(run), .bclk_out(sec_bclk_in));
    asc_clock_ratio_top #(.STOP_CYCLES(200), .INT_HALF(HALF)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sec_bclk_in(sec_bclk_in),
        .sec_ctrl_mode_in(sec_ctrl_mode_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .pri_sync_src_err_in(c0),
        .sec_sync_src_err_in(c1), .rate_conv_err_in(c2), .custom_mn_in(c3),
        .elem_match_err_in(c4), .density_mod_err_in(c5),
        .pri_ratio_err_in(c6), .sec_ratio_err_in(c7), .ctrl_sync_err_in(c8),
        .pri_sync_rate_err_in(c9), .sec_sync_rate_err_in(c10),
        .reg_rdata_out(reg_rdata_out), .sec_fsync_out(sec_fsync_out),
        .int_bclk_out(int_bclk_out));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] ea(input logic [10:0] c);
        return {c[0] | c[1], 2'h0, c[2] & ~c[3], c[4], c[5], 2'h0};
    endfunction
    function automatic logic [7:0] eb(input logic [10:0] c);
        return {c[6], c[7], c[8], c[9], c[10], 3'h0};
    endfunction
    task automatic cmp(input string n, input logic [15:0] e,
        input logic [15:0] v);
        n_tests++;
        if (v !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, v);
            error_cnt++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cyc();
        @(posedge clk_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        cyc();
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        exp_q.push_back(e);
        cyc();
        reg_rd_in = 1'b0;
        cyc();
    endtask
    task automatic cfg(input logic [7:0] c, input logic [7:0] l);
        wr(ASC_OFS_FSYNC_GEN_CTRL, c);
        cyc();
        wr(ASC_OFS_RATIO_LOW, l);
        cyc();
        // Both settings must cross to the link before any measuring
        repeat (400) cyc();
    endtask
    // Rise to rise distance of the frame sync, in core cycles
    task automatic gap(output int n);
        n = 0;
        while (sec_fsync_out !== 1'b1 && n < 3000) begin
            cyc();
            n++;
        end
        n = 0;
        do begin
            cyc();
            n++;
        end while (sec_fsync_out === 1'b1 && n < 3000);
        while (sec_fsync_out !== 1'b1 && n < 3000) begin
            cyc();
            n++;
        end
    endtask
    // Read results checked one cycle after the read is taken
    always @(posedge clk_in) rd_d <= reg_rd_in;
    always @(negedge clk_in) begin
        if (rd_d === 1'b1 && exp_q.size() > 0)
            cmp("rdata", {8'h00, exp_q.pop_front()},
                {8'h00, reg_rdata_out});
    end
    // Hang guard
    always @(posedge clk_in) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        cyc();
        for (int a = 0; a < 4; a++) rd(8'h3a + 8'(a), 8'h00);
        for (int i = 0; i < 4; i++) begin
            r = xs();
            wr(ASC_OFS_FSYNC_GEN_CTRL, r[7:0]);
            rd(ASC_OFS_FSYNC_GEN_CTRL, r[7:0]);
            wr(ASC_OFS_RATIO_LOW, r[15:8]);
            rd(ASC_OFS_RATIO_LOW, r[15:8]);
        end
        wr(ASC_OFS_ERR_A, 8'h9e);
        rd(ASC_OFS_ERR_A, 8'h00);
        wr(ASC_OFS_ERR_B, 8'hf8);
        rd(ASC_OFS_ERR_B, 8'h00);
        wr(8'h77, 8'hff);
        rd(8'h77, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 18; i++) begin
            r = xs();
            cond = (i < 11) ? 11'h001 << i : (i == 11) ? 11'h00c : r[10:0];
            cyc();
            rd(ASC_OFS_ERR_A, ea(cond));
            rd(ASC_OFS_ERR_B, eb(cond));
        end
        cond = 11'h000;
        $display("test flags done");
        // ratio floor and generated frame period
        sec_ctrl_mode_in = 1'b1;
        cfg(8'h80, 8'h01);
        rd(ASC_OFS_ERR_B, 8'h40);
        cfg(8'h80, 8'h02);
        rd(ASC_OFS_ERR_B, 8'h00);
        gap(g);
        gap(g);
        cmp("int_gap", 16'(2 * 2 * HALF), 16'(g));
        cfg(8'hc0, 8'h02);
        gap(g);
        gap(g);
        cmp("inv_gap", 16'(2 * 2 * HALF), 16'(g));
        cfg(8'h81, 8'h02);
        gap(g);
        gap(g);
        cmp("hi_gap", 16'(258 * 2 * HALF), 16'(g));
        cfg(8'h00, 8'h04);
        gap(g);
        gap(g);
        cmp("ext_gap", 16'h1, 16'(g >= 99 && g <= 101));
        cfg(8'h40, 8'h04);
        gap(g);
        gap(g);
        cmp("ext_inv_gap", 16'h1, 16'(g >= 99 && g <= 101));
        sec_ctrl_mode_in = 1'b0;
        repeat (8) cyc();
        k = 0;
        repeat (200) begin
            cyc();
            k += int'(sec_fsync_out);
        end
        cmp("off_pulses", 16'h0, 16'(k));
        $display("test frame sync done");
        // stop of the bit clock, short of and past the limit
        run = 1'b0;
        repeat (150) cyc();
        rd(ASC_OFS_ERR_A, 8'h00);
        repeat (60) cyc();
        rd(ASC_OFS_ERR_A, 8'h02);
        run = 1'b1;
        repeat (30) cyc();
        rd(ASC_OFS_ERR_A, 8'h00);
        $display("test clock stop done");
        repeat (4) cyc();
        close_out();
    end
endmodule

bind asc_clock_ratio_top asc_props #(.INT_HALF(INT_HALF)) u_props (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .sec_ctrl_mode_in(sec_ctrl_mode_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .pri_sync_src_err_in(pri_sync_src_err_in),
    .sec_sync_src_err_in(sec_sync_src_err_in),
    .rate_conv_err_in(rate_conv_err_in), .custom_mn_in(custom_mn_in),
    .elem_match_err_in(elem_match_err_in),
    .density_mod_err_in(density_mod_err_in),
    .pri_ratio_err_in(pri_ratio_err_in), .sec_ratio_err_in(sec_ratio_err_in),
    .ctrl_sync_err_in(ctrl_sync_err_in),
    .pri_sync_rate_err_in(pri_sync_rate_err_in),
    .sec_sync_rate_err_in(sec_sync_rate_err_in),
    .reg_rdata_out(reg_rdata_out), .sec_fsync_out(sec_fsync_out),
    .int_bclk_out(int_bclk_out));

`default_nettype wire
